// >>> design/beam_scan_sequencer.sv
`timescale 1ns/1ps
module beam_scan_sequencer #(
	parameter int OVERHEAD_CYC = beam_scan_pkg::OVERHEAD_CYC_DEF,
	parameter int MIN_CYCLE_CYC = beam_scan_pkg::MIN_CYCLE_CYC_DEF
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire beam_scan_pkg::beamMode_e beamMode,
	input wire logic [beam_scan_pkg::AXIS_W-1:0] axisCount,
	input wire logic [beam_scan_pkg::LEVEL_W-1:0] lightLevel,
	input wire logic [beam_scan_pkg::LEVEL_W-1:0] switchOnThreshold,
	output logic emitterOn,
	output logic detectorEn,
	output beam_scan_pkg::beamPath_s beamPath,
	output beam_scan_pkg::scanResult_s result,
	output logic resultValid
);
	localparam int CW = beam_scan_pkg::CYC_W;
	localparam int BW = beam_scan_pkg::BEAM_W;
	localparam int MB = beam_scan_pkg::MAX_BEAMS;

	beam_scan_pkg::scanState_e state_q;
	beam_scan_pkg::beamMode_e mode_q;
	logic [beam_scan_pkg::AXIS_W-1:0] axes_q;
	logic [BW-1:0] beamCount_q;
	logic [BW-1:0] beamIdx_q;
	logic [beam_scan_pkg::IDX_W-1:0] axis_q;
	logic [1:0] sub_q;
	logic [MB-1:0] freeMask_q;
	logic [CW-1:0] cycleCnt_q;
	logic [CW-1:0] xferCnt_q;
	beam_scan_pkg::beamPath_s path_q;
	beam_scan_pkg::scanResult_s result_q;
	logic resultValid_q;

	logic slotEnd;
	logic inScan;
	logic isFree;
	logic lastBeam;
	logic [1:0] subLast;
	logic xferDone;
	logic minReached;
	logic startNew;
	logic [beam_scan_pkg::AXIS_W-1:0] axesSafe;
	logic [MB-1:0] beamBit;
	logic [MB-1:0] maskNext;
	logic [beam_scan_pkg::IDX_W-1:0] axisNext;
	logic [1:0] subNext;

	beam_slot_timer slotTimer (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.run(inScan),
		.slotEnd(slotEnd)
	);

	assign inScan = (state_q == beam_scan_pkg::ST_SCAN);
	assign isFree = (lightLevel > switchOnThreshold);
	assign lastBeam = (beamIdx_q == beamCount_q - BW'(1));
	assign beamBit = MB'(1) << beamIdx_q;
	assign maskNext = isFree ? (freeMask_q | beamBit) : (freeMask_q & ~beamBit);
	// Sub-step pattern: parallel only, diagonal adds k->k+1, crossed adds k+1->k
	assign subLast = (mode_q == beam_scan_pkg::MODE_CROSSED) ? 2'h2 :
		(mode_q == beam_scan_pkg::MODE_DIAGONAL) ? 2'h1 : 2'h0;
	assign axisNext = (sub_q == subLast) ? axis_q + beam_scan_pkg::IDX_W'(1) : axis_q;
	assign subNext = (sub_q == subLast) ? 2'h0 : sub_q + 2'h1;
	assign xferDone = (state_q == beam_scan_pkg::ST_XFER) && (xferCnt_q == CW'(OVERHEAD_CYC - 1));
	assign minReached = (cycleCnt_q >= CW'(MIN_CYCLE_CYC - 1));
	assign startNew = (state_q == beam_scan_pkg::ST_IDLE) ||
		((xferDone || state_q == beam_scan_pkg::ST_PAD) && minReached);
	// Zero axes would give an empty scan; clamp into the supported range
	assign axesSafe = (axisCount == '0) ? beam_scan_pkg::AXIS_W'(1) :
		(axisCount > beam_scan_pkg::AXIS_W'(beam_scan_pkg::MAX_AXES)) ?
		beam_scan_pkg::AXIS_W'(beam_scan_pkg::MAX_AXES) : axisCount;

	assign emitterOn = inScan;
	assign detectorEn = inScan;
	assign beamPath = path_q;
	assign result = result_q;
	assign resultValid = resultValid_q;

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			state_q <= beam_scan_pkg::ST_IDLE;
		else if (startNew)
			state_q <= beam_scan_pkg::ST_SCAN;
		else
		begin
			case (state_q)
				beam_scan_pkg::ST_SCAN: if (slotEnd && lastBeam) state_q <= beam_scan_pkg::ST_XFER;
				beam_scan_pkg::ST_XFER: if (xferDone) state_q <= beam_scan_pkg::ST_PAD;
				beam_scan_pkg::ST_PAD: state_q <= beam_scan_pkg::ST_PAD;
				default: state_q <= beam_scan_pkg::ST_IDLE;
			endcase
		end
	end

	// Mode and axes are taken once per cycle so a scan never changes shape midway
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			mode_q <= beam_scan_pkg::MODE_PARALLEL;
			axes_q <= beam_scan_pkg::AXIS_W'(1);
			beamCount_q <= BW'(1);
		end
		else if (startNew)
		begin
			mode_q <= beamMode;
			axes_q <= axesSafe;
			beamCount_q <= beam_scan_pkg::logical_count(beamMode, axesSafe);
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			beamIdx_q <= '0;
			axis_q <= '0;
			sub_q <= 2'h0;
			path_q <= '0;
		end
		else if (startNew)
		begin
			beamIdx_q <= '0;
			axis_q <= '0;
			sub_q <= 2'h0;
			path_q <= beam_scan_pkg::path_for('0, 2'h0);
		end
		else if (inScan && slotEnd && !lastBeam)
		begin
			beamIdx_q <= beamIdx_q + BW'(1);
			axis_q <= axisNext;
			sub_q <= subNext;
			path_q <= beam_scan_pkg::path_for(axisNext, subNext);
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			freeMask_q <= '0;
		else if (startNew)
			freeMask_q <= '0;
		else if (inScan && slotEnd)
			freeMask_q <= maskNext;
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cycleCnt_q <= '0;
			xferCnt_q <= '0;
		end
		else
		begin
			// No saturation: longest cycle fits, and the wrap value is the full length minus one
			cycleCnt_q <= startNew ? '0 : cycleCnt_q + CW'(1);
			xferCnt_q <= (state_q == beam_scan_pkg::ST_XFER) ? xferCnt_q + CW'(1) : '0;
		end
	end

	// Result published only at the end of the transfer overhead
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			result_q <= '0;
			resultValid_q <= 1'b0;
		end
		else
		begin
			resultValid_q <= xferDone;
			if (xferDone)
				result_q <= '{freeMask: freeMask_q, beamCount: beamCount_q};
		end
	end

	// Checking helpers
	logic [CW-1:0] slotAge_q;
	logic [CW-1:0] expectLen;
	logic [CW-1:0] workLen;

	assign workLen = CW'(beamCount_q) * CW'(beam_scan_pkg::SLOT_CYC) + CW'(OVERHEAD_CYC);
	assign expectLen = (workLen > CW'(MIN_CYCLE_CYC)) ? workLen : CW'(MIN_CYCLE_CYC);

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			slotAge_q <= '0;
		else if (!inScan || slotEnd)
			slotAge_q <= '0;
		else
			slotAge_q <= slotAge_q + CW'(1);
	end

	sequence lastSlotS;
		inScan && slotEnd && lastBeam;
	endsequence

	sequence wrapS;
		startNew && state_q != beam_scan_pkg::ST_IDLE;
	endsequence

	slot_length_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		slotEnd |-> slotAge_q == CW'(beam_scan_pkg::SLOT_CYC - 1))
		else $error("beam slot length wrong");
	free_class_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(inScan && slotEnd) |=> freeMask_q[$past(beamIdx_q)] == $past(lightLevel > switchOnThreshold))
		else $error("beam classified wrongly");
	path_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(inScan && !slotEnd) |=> $stable(path_q) && $stable(beamIdx_q))
		else $error("beam changed inside slot");
	parallel_path_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(inScan && mode_q == beam_scan_pkg::MODE_PARALLEL) |-> path_q.emitIdx == path_q.detIdx
			&& BW'(path_q.emitIdx) == beamIdx_q)
		else $error("parallel detector mismatch");
	cycle_len_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		wrapS |-> cycleCnt_q + CW'(1) == expectLen)
		else $error("cycle length wrong");
	min_cycle_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		wrapS |-> cycleCnt_q >= CW'(MIN_CYCLE_CYC - 1))
		else $error("cycle shorter than minimum");
	xfer_order_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		lastSlotS |=> state_q == beam_scan_pkg::ST_XFER && !emitterOn && !resultValid)
		else $error("transfer not after last beam");
	result_time_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		resultValid |-> $past(state_q == beam_scan_pkg::ST_XFER) && result.beamCount == $past(beamCount_q))
		else $error("result outside transfer");
	diag_count_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(inScan && mode_q == beam_scan_pkg::MODE_DIAGONAL) |-> beamCount_q == BW'(2 * axes_q - 1))
		else $error("diagonal beam count wrong");
	cross_count_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(inScan && mode_q == beam_scan_pkg::MODE_CROSSED) |-> beamCount_q == BW'(3 * axes_q - 2))
		else $error("crossed beam count wrong");
	restart_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		wrapS |=> inScan && beamIdx_q == '0 && path_q == '0)
		else $error("no restart at first beam");
endmodule : beam_scan_sequencer

// >>> design/beam_slot_timer.sv
`timescale 1ns/1ps
module beam_slot_timer (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic run,
	output logic slotEnd
);
	logic [beam_scan_pkg::SLOT_W-1:0] cnt_q;
	logic lastTick;

	assign lastTick = (cnt_q == beam_scan_pkg::SLOT_W'(beam_scan_pkg::SLOT_CYC - 1));
	assign slotEnd = run && lastTick;

	// Restarts from zero whenever run drops, so every slot is full length
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			cnt_q <= '0;
		else if (!run || lastTick)
			cnt_q <= '0;
		else
			cnt_q <= cnt_q + beam_scan_pkg::SLOT_W'(1);
	end
endmodule : beam_slot_timer

// >>> inc/beam_scan_pkg.sv
package beam_scan_pkg;

	localparam int CLK_PERIOD_NS = 10;
	// Per-beam slot, emitter on to evaluation
	localparam int SLOT_US = 10;
	localparam int SLOT_CYC = SLOT_US * 1000 / CLK_PERIOD_NS;
	// Result transfer overhead, 0.20 ms
	localparam int OVERHEAD_US = 200;
	localparam int OVERHEAD_CYC_DEF = OVERHEAD_US * 1000 / CLK_PERIOD_NS;
	// Shortest allowed cycle, 1 ms
	localparam int MIN_CYCLE_US = 1000;
	localparam int MIN_CYCLE_CYC_DEF = MIN_CYCLE_US * 1000 / CLK_PERIOD_NS;

	localparam int MAX_AXES = 64;
	localparam int AXIS_W = 7;
	localparam int IDX_W = 6;
	localparam int MAX_BEAMS = 3 * MAX_AXES - 2;
	localparam int BEAM_W = 8;
	localparam int LEVEL_W = 12;
	localparam int CYC_W = 20;
	localparam int SLOT_W = 10;

	typedef enum logic [1:0] {
		MODE_PARALLEL = 2'h0,
		MODE_DIAGONAL = 2'h1,
		MODE_CROSSED = 2'h2
	} beamMode_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SCAN = 2'b01,
		ST_XFER = 2'b10,
		ST_PAD = 2'b11
	} scanState_e;

	typedef struct packed {
		logic [IDX_W-1:0] emitIdx;
		logic [IDX_W-1:0] detIdx;
	} beamPath_s;

	typedef struct packed {
		logic [MAX_BEAMS-1:0] freeMask;
		logic [BEAM_W-1:0] beamCount;
	} scanResult_s;

	function automatic logic [BEAM_W-1:0] logical_count(input beamMode_e mode, input logic [AXIS_W-1:0] axes);
		logic [BEAM_W-1:0] a;
		a = BEAM_W'(axes);
		case (mode)
			MODE_DIAGONAL: logical_count = (a << 1) - BEAM_W'(1);
			MODE_CROSSED: logical_count = (a << 1) + a - BEAM_W'(2);
			default: logical_count = a;
		endcase
	endfunction : logical_count

	function automatic beamPath_s path_for(input logic [IDX_W-1:0] axis, input logic [1:0] sub);
		path_for.emitIdx = axis;
		path_for.detIdx = axis;
		if (sub == 2'h1)
			path_for.detIdx = axis + IDX_W'(1);
		else if (sub == 2'h2)
			path_for.emitIdx = axis + IDX_W'(1);
	endfunction : path_for

endpackage : beam_scan_pkg

// >>> tb/beam_optics_model.sv
`timescale 1ns/1ps
module beam_optics_model (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic emitterOn,
	input wire logic detectorEn,
	input wire beam_scan_pkg::beamPath_s beamPath,
	input wire logic [63:0] shade,
	output logic [beam_scan_pkg::LEVEL_W-1:0] lightLevel
);
	logic [11:0] noise_q;
	wire logic lit = emitterOn & detectorEn;
	// An object in front of either lens darkens the beam
	wire logic blocked = shade[beamPath.emitIdx] | shade[beamPath.detIdx];

	// Dark optics give a level that changes every cycle, never a stale value
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			noise_q <= 12'h5A5;
		else
			noise_q <= noise_q + 12'h3B7;
	end

	assign lightLevel = lit ? (blocked ? 12'h200 : 12'hA00) : noise_q;
endmodule : beam_optics_model

// >>> tb/test_beam_scan_sequencer.sv
`timescale 1ns/1ps
module test_beam_scan_sequencer;
	localparam int OVH = 20;
	localparam int MINC = 3000;
	localparam int SLOT = beam_scan_pkg::SLOT_CYC;
	localparam int LIM = 20000;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	beam_scan_pkg::beamMode_e beamMode = beam_scan_pkg::MODE_PARALLEL;
	logic [6:0] axisCount = 7'h02;
	logic [11:0] lightLevel;
	logic [11:0] switchOnThreshold = 12'h200;
	logic emitterOn;
	logic detectorEn;
	logic resultValid;
	beam_scan_pkg::beamPath_s beamPath;
	beam_scan_pkg::scanResult_s result;
	logic [63:0] shade = 64'h0;
	logic [31:0] seed = 32'h2BAE6BA0;
	logic [1:0] curMode = 2'h0;
	int curAxes = 2;
	int mismatches = 0;
	int check_count = 0;

	beam_scan_sequencer #(.OVERHEAD_CYC(OVH), .MIN_CYCLE_CYC(MINC)) DUT (.core_clk(core_clk), .sys_rst(sys_rst),
		.beamMode(beamMode), .axisCount(axisCount), .lightLevel(lightLevel), .switchOnThreshold(switchOnThreshold),
		.emitterOn(emitterOn), .detectorEn(detectorEn), .beamPath(beamPath), .result(result),
		.resultValid(resultValid));

	beam_optics_model optics (.core_clk(core_clk), .sys_rst(sys_rst), .emitterOn(emitterOn),
		.detectorEn(detectorEn), .beamPath(beamPath), .shade(shade), .lightLevel(lightLevel));

	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr_next

	function automatic int beams(input logic [1:0] m, input int a);
		if (a == 0)
			a = 1;
		return (m == 2'h1) ? 2 * a - 1 : (m == 2'h2) ? 3 * a - 2 : a;
	endfunction : beams

	function automatic logic [11:0] path_of(input logic [1:0] m, input int j);
		int k;
		int s;
		k = (m == 2'h0) ? j : (m == 2'h1) ? j / 2 : j / 3;
		s = (m == 2'h0) ? 0 : (m == 2'h1) ? j % 2 : j % 3;
		return {6'(k + (s == 2)), 6'(k + (s == 1))};
	endfunction : path_of

	function automatic logic [189:0] exp_mask(input logic [1:0] m, input int a, input logic [63:0] sh,
		input logic [11:0] thr);
		logic [11:0] p;
		logic [189:0] r;
		r = '0;
		for (int j = 0; j < beams(m, a); j++)
		begin
			p = path_of(m, j);
			r[j] = (((sh[p[11:6]] | sh[p[5:0]]) ? 12'h200 : 12'hA00) > thr);
		end
		return r;
	endfunction : exp_mask

	task automatic check(input logic [199:0] seen, input logic [199:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check

	task automatic print_verdict;
		$display("Checks %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict

	// Called at the falling edge of a cycle's first scan clock; nm/na take effect only next cycle
	task automatic run_cycle(input logic [1:0] nm, input int na);
		int n;
		int c;
		logic [189:0] em;
		n = beams(curMode, curAxes);
		seed = lfsr_next(seed);
		shade = {seed, lfsr_next(seed)};
		case (seed[5:4])
			2'h0: switchOnThreshold = 12'h200;
			2'h1: switchOnThreshold = 12'h1FF;
			2'h2: switchOnThreshold = 12'hA00;
			default: switchOnThreshold = 12'h9FF;
		endcase
		beamMode = beam_scan_pkg::beamMode_e'(nm);
		axisCount = 7'(na);
		em = exp_mask(curMode, curAxes, shade, switchOnThreshold);
		// Without padding the previous result pulse shares cycle 0
		for (c = 0; c < LIM && (c == 0 || resultValid !== 1'b1); c++)
		begin
			if (c == 1)
				check(resultValid, 1'b0);
			if (c % SLOT == SLOT / 2 && c < n * SLOT)
			begin
				check(beamPath, path_of(curMode, c / SLOT));
				check({emitterOn, detectorEn}, 2'h3);
			end
			if (c == n * SLOT + OVH / 2)
				check(emitterOn, 1'b0);
			@(negedge core_clk);
		end
		check(c, n * SLOT + OVH);
		check(result.freeMask, em);
		check(result.beamCount, 8'(n));
		for (; c < LIM && !(emitterOn === 1'b1 && c > n * SLOT); c++)
			@(negedge core_clk);
		check(c, (n * SLOT + OVH > MINC) ? n * SLOT + OVH : MINC);
		if (c >= LIM)
		begin
			mismatches++;
			print_verdict();
		end
		curMode = nm;
		curAxes = na;
	endtask : run_cycle

	initial
	begin
		forever #5 core_clk = ~core_clk;
	end

	initial
	begin
		logic [1:0] cm [5];
		int ca [5];
		int c;
		cm = '{2'h1, 2'h2, 2'h2, 2'h1, 2'h0};
		ca = '{1, 0, 4, 3, 4};
		repeat (10) @(negedge core_clk);
		check(emitterOn, 1'b0);
		check(resultValid, 1'b0);
		check(result, '0);
		sys_rst = 1'b0;
		for (c = 0; c < 10 && emitterOn !== 1'b1; c++)
			@(negedge core_clk);
		check(emitterOn, 1'b1);
		for (int t = 0; t < 9; t++)
		begin
			seed = lfsr_next(seed);
			// Hand-picked corners first: padding, single beam, zero axes, no padding
			if (t < 5)
				run_cycle(cm[t], ca[t]);
			else
				run_cycle(2'(seed % 32'd3), 1 + int'(seed[3:2]));
			$display("Test %0d done", t);
		end
		print_verdict();
	end
endmodule : test_beam_scan_sequencer
